// ==== logic/tmr_pkg.sv ====
// Package for the two-channel capture/compare timer core.
// Assumes one system clock; register indices are local to this block.
package tmr_pkg;

  localparam int NUM_CH = 2;

  // Register indices per channel: address = {channel, index}
  localparam logic [2:0] IDX_IRQ_EN   = 3'h0;
  localparam logic [2:0] IDX_STATUS   = 3'h1;
  localparam logic [2:0] IDX_COUNTER  = 3'h2;
  localparam logic [2:0] IDX_GEN_A    = 3'h3;
  localparam logic [2:0] IDX_GEN_B    = 3'h4;
  localparam logic [2:0] IDX_CONTROL  = 3'h5;
  localparam logic [3:0] ADDR_RUN     = 4'hf;

  // Interrupt enable field positions
  localparam int IE_SPARE7 = 7;
  localparam int IE_ONE6   = 6;
  localparam int IE_OVF    = 4;
  localparam int IE_B      = 1;
  localparam int IE_A      = 0;

  // Status field positions
  localparam int ST_OVF = 4;
  localparam int ST_B   = 1;
  localparam int ST_A   = 0;
  localparam logic [7:0] ST_FIXED_ONES = 8'hc0;

  // Control fields: bits 3:0 mode of A, bits 7:4 mode of B
  localparam int CT_A_LSB = 0;
  localparam int CT_B_LSB = 4;

  // Reset values and counter maximum
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [15:0] GEN_RST     = 16'hffff;
  localparam logic [15:0] COUNTER_MAX = 16'hffff;

  // Capture edge selection from the low two bits of an I/O mode nibble
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_BOTH2 = 2'b11
  } edge_sel_e;

  // Per-channel interrupt requests
  typedef struct packed {
    logic overflow_irq;
    logic reg_b_irq;
    logic reg_a_irq;
  } irq_s;

endpackage

// ==== logic/timer_channel_flags_counter.sv ====
// Two-channel 16-bit timer core: counters, compare/capture registers, flags.
// Assumes a CPU register port on clk_i and asynchronous capture pins.
`timescale 1ns/10ps

module timer_channel_flags_counter (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  standby_i,
  // Register port
  input  wire logic [3:0]            addr_i,
  input  wire logic [15:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [15:0]           rdata_o,
  // Capture pins, one per general register
  input  wire logic [1:0]            cap_a_pin_i,
  input  wire logic [1:0]            cap_b_pin_i,
  // Interrupt requests
  output tmr_pkg::irq_s [1:0]        irq_o
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Capture edge detect on a synchronised level
  function automatic logic edge_hit(input logic [3:0] mode, input logic cur,
                                    input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (edge_sel_e'(mode[1:0]))
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      default:   edge_hit = rise | fall;
    endcase
  endfunction

  // Decode of a channel register access, used for writes and for the status read
  function automatic logic hit(input logic [3:0] a, input int ch, input logic [2:0] idx);
    hit = (a[3] == ch[0]) && (a[2:0] == idx) && (a != ADDR_RUN);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  irq_en     [NUM_CH];
  logic [2:0]  flags      [NUM_CH];  // {ovf, b, a}
  logic [2:0]  flag_seen  [NUM_CH];  // flag read as one since last write
  logic [15:0] counter    [NUM_CH];
  logic [15:0] gen_a      [NUM_CH];
  logic [15:0] gen_b      [NUM_CH];
  logic [7:0]  io_mode    [NUM_CH];
  logic [1:0]  run;
  logic [1:0]  a_sync1, a_sync2, a_prev;
  logic [1:0]  b_sync1, b_sync2, b_prev;
  logic [1:0]  stby_sync;
  logic [2:0]  next_set   [NUM_CH];

  // Two-stage synchronisers for pins and standby, plus edge history
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      a_sync1   <= 2'b00;
      a_sync2   <= 2'b00;
      a_prev    <= 2'b00;
      b_sync1   <= 2'b00;
      b_sync2   <= 2'b00;
      b_prev    <= 2'b00;
      stby_sync <= 2'b00;
    end else begin
      a_sync1   <= cap_a_pin_i;
      a_sync2   <= a_sync1;
      a_prev    <= a_sync2;
      b_sync1   <= cap_b_pin_i;
      b_sync2   <= b_sync1;
      b_prev    <= b_sync2;
      stby_sync <= {stby_sync[0], standby_i};
    end
  end

  // Counter run bits, one per channel
  // run bits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run <= 2'b00;
    end else if (wr_i && addr_i == ADDR_RUN) begin
      run <= wdata_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-channel logic
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic cap_a;
    logic cap_b;
    logic a_is_cap;
    logic b_is_cap;
    logic wrap;

    assign a_is_cap = io_mode[ch][CT_A_LSB+3];
    assign b_is_cap = io_mode[ch][CT_B_LSB+3];
    assign cap_a = a_is_cap & edge_hit(io_mode[ch][CT_A_LSB +: 4], a_sync2[ch], a_prev[ch]);
    assign cap_b = b_is_cap & edge_hit(io_mode[ch][CT_B_LSB +: 4], b_sync2[ch], b_prev[ch]);
    // A software counter write in the wrap cycle overrides counting, so no overflow then
    assign wrap  = run[ch] & (counter[ch] == COUNTER_MAX) & ~stby_sync[1]
                   & ~(wr_i && hit(addr_i, ch, IDX_COUNTER));

    // Flag set sources in this cycle
    always_comb begin
      next_set[ch] = 3'b000;
      next_set[ch][2] = wrap;
      next_set[ch][1] = b_is_cap ? cap_b : (counter[ch] == gen_b[ch]);
      next_set[ch][0] = a_is_cap ? cap_a : (counter[ch] == gen_a[ch]);
    end

    // Counter: cleared by reset and standby, else write, else count
    always_ff @(posedge clk_i) begin
      if (sys_rst_i || stby_sync[1]) begin
        counter[ch] <= COUNTER_RST;
      end else if (wr_i && hit(addr_i, ch, IDX_COUNTER)) begin
        counter[ch] <= wdata_i;
      end else if (run[ch]) begin
        counter[ch] <= counter[ch] + 16'h0001;
      end
    end

    // General registers: software write, or capture of the counter
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        gen_a[ch] <= GEN_RST;
        gen_b[ch] <= GEN_RST;
      end else begin
        if (cap_a) begin
          gen_a[ch] <= counter[ch];
        end else if (wr_i && hit(addr_i, ch, IDX_GEN_A)) begin
          gen_a[ch] <= wdata_i;
        end
        if (cap_b) begin
          gen_b[ch] <= counter[ch];
        end else if (wr_i && hit(addr_i, ch, IDX_GEN_B)) begin
          gen_b[ch] <= wdata_i;
        end
      end
    end

    // Enable and I/O mode registers
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        irq_en[ch]  <= 8'h00;
        io_mode[ch] <= 8'h00;
      end else begin
        if (wr_i && hit(addr_i, ch, IDX_IRQ_EN)) begin
          irq_en[ch] <= wdata_i[7:0] & 8'h93;
        end
        if (wr_i && hit(addr_i, ch, IDX_CONTROL)) begin
          io_mode[ch] <= wdata_i[7:0];
        end
      end
    end

    // Flags and read-as-one memory for the clear handshake
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        flags[ch]     <= 3'b000;
        flag_seen[ch] <= 3'b000;
      end else if (wr_i && hit(addr_i, ch, IDX_STATUS)) begin
        // clear after read; ones ignored; set wins
        flags[ch] <= next_set[ch] | (flags[ch] & ~(flag_seen[ch] &
                     ~{wdata_i[ST_OVF], wdata_i[ST_B], wdata_i[ST_A]}));
        flag_seen[ch] <= 3'b000;
      end else begin
        flags[ch] <= flags[ch] | next_set[ch];
        if (rd_i && hit(addr_i, ch, IDX_STATUS)) begin
          flag_seen[ch] <= flag_seen[ch] | flags[ch];
        end
      end
    end

    // Requests follow flag AND enable
    // gated requests
    assign irq_o[ch].overflow_irq = flags[ch][2] & irq_en[ch][IE_OVF];
    assign irq_o[ch].reg_b_irq    = flags[ch][1] & irq_en[ch][IE_B];
    assign irq_o[ch].reg_a_irq    = flags[ch][0] & irq_en[ch][IE_A];
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      if (addr_i == ADDR_RUN) begin
        rdata_o <= {14'h0000, run};
      end else begin
        case (addr_i[2:0])
          IDX_IRQ_EN:  rdata_o <= {8'h00, irq_en[addr_i[3]] | 8'h40};
          IDX_STATUS:  rdata_o <= {8'h00, ST_FIXED_ONES | {3'b000, flags[addr_i[3]][2],
                                   2'b00, flags[addr_i[3]][1:0]}};
          IDX_COUNTER: rdata_o <= counter[addr_i[3]];
          IDX_GEN_A:   rdata_o <= gen_a[addr_i[3]];
          IDX_GEN_B:   rdata_o <= gen_b[addr_i[3]];
          IDX_CONTROL: rdata_o <= {8'h00, io_mode[addr_i[3]]};
          default:     rdata_o <= 16'h0000;
        endcase
      end
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // timer_channel_flags_counter

// ==== dv/tmr_core_chk.sv ====
// Checker of port-level timing for the two-channel timer core.
// Assumes one clock and the registered read port of the core.
`timescale 1ns/10ps

module tmr_core_chk (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  input wire logic                 standby_i,
  // Register port
  input wire logic [3:0]           addr_i,
  input wire logic [15:0]          wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [15:0]          rdata_o,
  // Requests
  input wire tmr_pkg::irq_s [1:0]  irq_o
);
  import tmr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Steps: enable write on channel 0, standby held long enough to clear
  sequence s_ie_wr0; wr_i && !addr_i[3] && addr_i[2:0] == IDX_IRQ_EN; endsequence
  sequence s_standby; standby_i [*5]; endsequence
  property p_rd_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_ie_fixed; rd_i && addr_i[2:0] == IDX_IRQ_EN |=> rdata_o[6] && rdata_o[3:2] == 2'b00;
  endproperty
  a_ie_fixed: assert property (p_ie_fixed) else $error("enable fixed bits");
  property p_st_fixed;
    rd_i && addr_i[2:0] == IDX_STATUS |=> rdata_o[7:5] == 3'b110 && rdata_o[3:2] == 2'b00;
  endproperty
  a_st_fixed: assert property (p_st_fixed) else $error("status fixed bits");
  property p_standby; s_standby ##0 (rd_i && addr_i[2:0] == IDX_COUNTER) |=> rdata_o == 0;
  endproperty
  a_standby: assert property (p_standby) else $error("counter not zero in standby");
  property p_a_gate; s_ie_wr0 ##0 !wdata_i[IE_A] |=> !irq_o[0].reg_a_irq; endproperty
  a_a_gate: assert property (p_a_gate) else $error("A request not gated");
  property p_b_gate; s_ie_wr0 ##0 !wdata_i[IE_B] |=> !irq_o[0].reg_b_irq; endproperty
  a_b_gate: assert property (p_b_gate) else $error("B request not gated");
  property p_ovf_gate; s_ie_wr0 ##0 !wdata_i[IE_OVF] |=> !irq_o[0].overflow_irq; endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request not gated");
  property p_irq_hold; irq_o[0].overflow_irq && !wr_i |=> irq_o[0].overflow_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
endmodule // tmr_core_chk

bind timer_channel_flags_counter tmr_core_chk i_tmr_core_chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .standby_i(standby_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// ==== dv/tmr_pin_model.sv ====
// Model of the capture pins driven from outside the timer.
// Assumes the core passes these pins through two-stage synchronisers on its clock.
`timescale 1ns/10ps

module tmr_pin_model (
  // Capture pins
  output logic [1:0] cap_a_o,
  output logic [1:0] cap_b_o
);
  // Pins idle low
  initial cap_a_o = 2'b00;
  initial cap_b_o = 2'b00;
  task automatic flip(input logic b, input int ch);
    if (b) cap_b_o[ch] = ~cap_b_o[ch];
    else cap_a_o[ch] = ~cap_a_o[ch];
  endtask
endmodule // tmr_pin_model

// ==== dv/tb_top.sv ====
// Testbench of the two-channel timer core.
// Assumes a 25 MHz clock and the pin model for capture inputs.
`timescale 1ns/10ps

module tb_top;
  import tmr_pkg::*;
  localparam logic [3:0] IE = 4'h0, ST = 4'h1, CT = 4'h2, GA = 4'h3, GB = 4'h4, MD = 4'h5;
  logic            clk_i, sys_rst_i, standby_i, wr_i, rd_i;
  logic [3:0]      addr_i;
  logic [15:0]     wdata_i, rdata_o, v;
  logic [1:0]      cap_a, cap_b;
  irq_s [1:0]      irq_o;
  int              errors, comparisons;
  timer_channel_flags_counter i_timer_channel_flags_counter (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .standby_i(standby_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_a_pin_i(cap_a), .cap_b_pin_i(cap_b),
    .irq_o(irq_o));
  tmr_pin_model i_tmr_pin_model (.cap_a_o(cap_a), .cap_b_o(cap_b));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Compare and bus tasks
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // every access is one whole 16-bit word
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e);
    rd(a, v);
    check(n, v, e);
  endtask
  // Scenarios
  task automatic t_reset;
    for (int c = 0; c < 2; c++) begin
      rdc("ie", {c[0], IE[2:0]}, 16'h0040);
      rdc("st", {c[0], ST[2:0]}, 16'h00c0);
      rdc("ct", {c[0], CT[2:0]}, 16'h0000);
      rdc("ga", {c[0], GA[2:0]}, 16'hffff);
      rdc("gb", {c[0], GB[2:0]}, 16'hffff);
    end
  endtask
  task automatic t_enable;
    wr(IE, 16'h00df);
    rdc("ie", IE, 16'h00d3);
    wr(IE, 16'h0000);
    rdc("ie", IE, 16'h0040);
    wr(CT, 16'h1234);
    repeat (3) @(posedge clk_i);
    rdc("ct", CT, 16'h1234);
  endtask
  task automatic t_overflow;
    wr(IE, 16'h0013);
    wr(CT, 16'hfffd);
    wr(ADDR_RUN, 16'h0001);
    repeat (6) @(posedge clk_i);
    wr(ADDR_RUN, 16'h0000);
    #1 check("irq", {13'h0, irq_o[0]}, 16'h0007);
    wr(IE, 16'h0001);
    #1 check("irq", {13'h0, irq_o[0]}, 16'h0001);
    wr(ST, 16'h0000);
    rdc("st", ST, 16'h00d3);
    wr(ST, 16'h0000);
    rdc("st", ST, 16'h00c0);
    #1 check("irq", {13'h0, irq_o[0]}, 16'h0000);
    wr(ST, 16'h00ff);
    rdc("st", ST, 16'h00c0);
  endtask
  task automatic t_capture;
    logic [15:0] mode [4] = '{16'h0008, 16'h0009, 16'h000a, 16'h0080};
    wr(CT, 16'h0100);
    wr(ADDR_RUN, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(MD, mode[i]);
      rd(ST, v);
      wr(ST, 16'h0000);
      #5 i_tmr_pin_model.flip(i == 3, 0);
      repeat (6) @(posedge clk_i);
      rdc("cap", ST, (i < 3) ? 16'h00c1 : 16'h00c2);
    end
    rd(GA, v);
    check("ga", {15'h0, v > 16'h0110 && v < 16'h0150}, 16'h0001);
  endtask
  task automatic t_chan1;
    wr(4'h8, 16'h0010);
    wr(4'ha, 16'hfffe);
    wr(ADDR_RUN, 16'h0002);
    repeat (4) @(posedge clk_i);
    wr(ADDR_RUN, 16'h0000);
    #1 check("irq1", {13'h0, irq_o[1]}, 16'h0004);
    rdc("st1", 4'h9, 16'h00d3);
    #1 check("irq0", {13'h0, irq_o[0]}, 16'h0000);
  endtask
  task automatic t_standby;
    standby_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rdc("ct", CT, 16'h0000);
    standby_i <= 1'b0;
    wr(ADDR_RUN, 16'h0000);
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {sys_rst_i, standby_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 23'h0};
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_enable;
    t_overflow;
    t_capture;
    t_chan1;
    t_standby;
    give_verdict;
  end
  // Hang guard
  initial begin
    #1000000 errors++;
    give_verdict;
  end
endmodule // tb_top
